//--- core/sed_bus.sv
// External memory access unit with stretched data moves
`timescale 1ns/1ps
module sed_bus (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 ce,
	// Special function register port
	input  wire logic [7:0]           sfr_addr,
	input  wire logic                 sfr_write,
	input  wire logic [7:0]           sfr_wdata,
	output logic      [7:0]           sfr_rdata,
	// Scratchpad port
	input  wire logic [7:0]           scratch_addr,
	input  wire logic                 scratch_write,
	input  wire logic [7:0]           scratch_wdata,
	output logic      [7:0]           scratch_rdata,
	// Program fetch requests
	input  wire logic                 fetch_req,
	input  wire logic [15:0]          fetch_addr,
	output logic                      fetch_ready,
	output logic                      fetch_done,
	output logic      [7:0]           fetch_data,
	// Data move requests
	input  wire logic                 move_req,
	input  wire logic                 move_write,
	input  wire logic                 move_use_pointer,
	input  wire logic [7:0]           move_addr_low,
	input  wire logic [7:0]           move_wdata,
	output logic                      move_ready,
	output logic                      move_done,
	output logic      [7:0]           move_rdata,
	// External bus pins
	input  wire logic [7:0]           low_port_in,
	output logic      [7:0]           low_port_out,
	output logic                      low_port_oe,
	output logic      [7:0]           high_port_out,
	output logic                      ale,
	output logic                      prog_strobe_n,
	output logic                      read_strobe_n,
	output logic                      write_strobe_n
);
	import sed_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0]  pointer0_low, pointer0_high, pointer1_low, pointer1_high;
	logic [7:0]  pointer_choice, cycle_speed_control, high_address_port;
	logic [7:0]  next_pointer0_low, next_pointer0_high, next_pointer1_low;
	logic [7:0]  next_pointer1_high, next_pointer_choice, next_cycle_speed;
	logic [7:0]  next_high_port, next_sfr_rdata;
	logic [2:0]  stretch;

	assign stretch = cycle_speed_control[STRETCH_MSB:STRETCH_LSB];

	always_comb
	begin
		next_pointer0_low   = pointer0_low;
		next_pointer0_high  = pointer0_high;
		next_pointer1_low   = pointer1_low;
		next_pointer1_high  = pointer1_high;
		next_pointer_choice = pointer_choice;
		next_cycle_speed    = cycle_speed_control;
		next_high_port      = high_address_port;
		if (sfr_write)
		begin
			case (sfr_addr)
				ADDR_POINTER0_LOW:   next_pointer0_low   = sfr_wdata;
				ADDR_POINTER0_HIGH:  next_pointer0_high  = sfr_wdata;
				ADDR_POINTER1_LOW:   next_pointer1_low   = sfr_wdata;
				ADDR_POINTER1_HIGH:  next_pointer1_high  = sfr_wdata;
				ADDR_POINTER_CHOICE: next_pointer_choice = sfr_wdata & CHOICE_WRITE_MASK;
				ADDR_CYCLE_SPEED:    next_cycle_speed    = sfr_wdata & SPEED_WRITE_MASK;
				ADDR_HIGH_PORT:      next_high_port      = sfr_wdata;
				default:             next_high_port      = high_address_port;
			endcase
		end
		case (sfr_addr)
			ADDR_POINTER0_LOW:   next_sfr_rdata = pointer0_low;
			ADDR_POINTER0_HIGH:  next_sfr_rdata = pointer0_high;
			ADDR_POINTER1_LOW:   next_sfr_rdata = pointer1_low;
			ADDR_POINTER1_HIGH:  next_sfr_rdata = pointer1_high;
			ADDR_POINTER_CHOICE: next_sfr_rdata = pointer_choice;
			ADDR_CYCLE_SPEED:    next_sfr_rdata = cycle_speed_control;
			ADDR_HIGH_PORT:      next_sfr_rdata = high_address_port;
			default:             next_sfr_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			pointer0_low        <= RESET_POINTER;
			pointer0_high       <= RESET_POINTER;
			pointer1_low        <= RESET_POINTER;
			pointer1_high       <= RESET_POINTER;
			pointer_choice      <= RESET_CHOICE;
			cycle_speed_control <= RESET_CYCLE_SPEED;
			high_address_port   <= RESET_HIGH_PORT;
			sfr_rdata           <= 8'h00;
		end
		else if (ce)
		begin
			pointer0_low        <= next_pointer0_low;
			pointer0_high       <= next_pointer0_high;
			pointer1_low        <= next_pointer1_low;
			pointer1_high       <= next_pointer1_high;
			pointer_choice      <= next_pointer_choice;
			cycle_speed_control <= next_cycle_speed;
			high_address_port   <= next_high_port;
			sfr_rdata           <= next_sfr_rdata;
		end
	end

	// ==========================================================
	// Scratchpad, the only on-chip memory
	logic [7:0] scratch_mem [SCRATCH_BYTES];

	always_ff @(posedge clk)
	begin
		if (ce && scratch_write)
			scratch_mem[scratch_addr] <= scratch_wdata;
		if (ce)
			scratch_rdata <= scratch_mem[scratch_addr];
	end

	// ==========================================================
	// Sequencer
	sed_state_t  state, next_state;
	logic [5:0]  cnt, next_cnt, last_cnt, next_last;
	logic [4:0]  width, next_width;
	logic [2:0]  move_stretch, next_move_stretch;
	logic [15:0] bus_addr, next_bus_addr;
	logic [7:0]  bus_wdata, next_bus_wdata;
	logic        bus_write, next_bus_write;
	logic        at_end, accept_fetch, accept_move;

	assign at_end       = (state != SED_IDLE) && (cnt == last_cnt);
	assign fetch_ready  = (state == SED_IDLE) || at_end;
	assign move_ready   = fetch_ready && !fetch_req;
	assign accept_fetch = ce && fetch_ready && fetch_req;
	assign accept_move  = ce && move_ready && move_req;

	always_comb
	begin
		next_state        = state;
		next_cnt          = cnt + 6'h01;
		next_last         = last_cnt;
		next_width        = width;
		next_move_stretch = move_stretch;
		next_bus_addr     = bus_addr;
		next_bus_wdata    = bus_wdata;
		next_bus_write    = bus_write;
		if (at_end)
			next_state = SED_IDLE;
		if (accept_fetch)
		begin
			next_state    = SED_FETCH;
			next_cnt      = 6'h00;
			next_last     = FETCH_LAST;
			next_bus_addr = fetch_addr;
		end
		else if (accept_move)
		begin
			next_state        = SED_MOVE;
			next_cnt          = 6'h00;
			next_move_stretch = stretch;
			next_last         = sed_move_clocks(stretch) - 6'h01;
			next_width        = sed_strobe_width(stretch);
			next_bus_write    = move_write;
			next_bus_wdata    = move_wdata;
			if (!move_use_pointer)
				next_bus_addr = {high_address_port, move_addr_low};
			else if (pointer_choice[0])
				next_bus_addr = {pointer1_high, pointer1_low};
			else
				next_bus_addr = {pointer0_high, pointer0_low};
		end
		else if (state == SED_IDLE)
			next_cnt = 6'h00;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state        <= SED_IDLE;
			cnt          <= 6'h00;
			last_cnt     <= 6'h00;
			width        <= FAST_STROBE_WIDTH;
			move_stretch <= RESET_STRETCH;
			bus_addr     <= 16'h0000;
			bus_wdata    <= 8'h00;
			bus_write    <= 1'b0;
		end
		else if (ce)
		begin
			state        <= next_state;
			cnt          <= next_cnt;
			last_cnt     <= next_last;
			width        <= next_width;
			move_stretch <= next_move_stretch;
			bus_addr     <= next_bus_addr;
			bus_wdata    <= next_bus_wdata;
			bus_write    <= next_bus_write;
		end
	end

	// ==========================================================
	// Pin decode, registered
	logic [7:0] next_low_out, next_high_out;
	logic       next_low_oe, next_ale, next_prog_n, next_rd_n, next_wr_n;
	logic       in_move_strobe, next_sample;
	logic [5:0] strobe_end;

	assign strobe_end     = MOVE_STROBE_FIRST + {1'b0, width};
	assign in_move_strobe = (state == SED_MOVE) && (cnt >= MOVE_STROBE_FIRST)
		&& (cnt < strobe_end);

	always_comb
	begin
		next_low_out  = RESET_LOW_PORT;
		next_low_oe   = 1'b0;
		next_high_out = high_address_port;
		next_ale      = 1'b0;
		next_prog_n   = 1'b1;
		next_rd_n     = 1'b1;
		next_wr_n     = 1'b1;
		next_sample   = 1'b0;
		case (state)
			SED_FETCH:
			begin
				next_high_out = bus_addr[15:8];
				next_ale      = (cnt == ALE_CLOCK);
				next_prog_n   = !((cnt >= FETCH_STROBE_FIRST) && (cnt <= FETCH_STROBE_LAST));
				next_sample   = (cnt == FETCH_STROBE_LAST);
				if (cnt <= ADDR_LAST)
				begin
					next_low_out = bus_addr[7:0];
					next_low_oe  = 1'b1;
				end
			end
			SED_MOVE:
			begin
				next_high_out = bus_addr[15:8];
				next_ale      = (cnt == ALE_CLOCK);
				next_rd_n     = !(in_move_strobe && !bus_write);
				next_wr_n     = !(in_move_strobe && bus_write);
				next_sample   = (cnt == strobe_end - 6'h01);
				if (cnt <= ADDR_LAST)
				begin
					next_low_out = bus_addr[7:0];
					next_low_oe  = 1'b1;
				end
				else if (bus_write && (cnt >= WRITE_DATA_FIRST) && (cnt <= strobe_end))
				begin
					next_low_out = bus_wdata;
					next_low_oe  = 1'b1;
				end
			end
			default:
			begin
				next_low_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			low_port_out   <= RESET_LOW_PORT;
			low_port_oe    <= 1'b0;
			high_port_out  <= RESET_HIGH_PORT;
			ale            <= 1'b0;
			prog_strobe_n  <= 1'b1;
			read_strobe_n  <= 1'b1;
			write_strobe_n <= 1'b1;
		end
		else if (ce)
		begin
			low_port_out   <= next_low_out;
			low_port_oe    <= next_low_oe;
			high_port_out  <= next_high_out;
			ale            <= next_ale;
			prog_strobe_n  <= next_prog_n;
			read_strobe_n  <= next_rd_n;
			write_strobe_n <= next_wr_n;
		end
	end

	// ==========================================================
	// Read capture behind the pin synchroniser
	logic [7:0]              low_port_sync;
	logic [SAMPLE_DELAY-1:0] sample_pipe, kind_pipe, next_sample_pipe, next_kind_pipe;
	logic [7:0]              next_fetch_data, next_move_rdata;
	logic                    next_fetch_done, next_move_done;

	sed_sync #(
		.WIDTH (8)
	) u_low_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.ce       (ce),
		.pin_in   (low_port_in),
		.sync_out (low_port_sync)
	);

	always_comb
	begin
		next_sample_pipe = {sample_pipe[SAMPLE_DELAY-2:0], next_sample};
		next_kind_pipe   = {kind_pipe[SAMPLE_DELAY-2:0], (state == SED_MOVE)};
		next_fetch_done  = sample_pipe[SAMPLE_DELAY-1] && !kind_pipe[SAMPLE_DELAY-1];
		next_move_done   = sample_pipe[SAMPLE_DELAY-1] && kind_pipe[SAMPLE_DELAY-1];
		next_fetch_data  = next_fetch_done ? low_port_sync : fetch_data;
		next_move_rdata  = move_rdata;
		if (next_move_done && read_strobe_n && write_strobe_n && !low_port_oe)
			next_move_rdata = low_port_sync;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			sample_pipe <= '0;
			kind_pipe   <= '0;
			fetch_done  <= 1'b0;
			move_done   <= 1'b0;
			fetch_data  <= 8'h00;
			move_rdata  <= 8'h00;
		end
		else if (ce)
		begin
			sample_pipe <= next_sample_pipe;
			kind_pipe   <= next_kind_pipe;
			fetch_done  <= next_fetch_done;
			move_done   <= next_move_done;
			fetch_data  <= next_fetch_data;
			move_rdata  <= next_move_rdata;
		end
	end

	// ==========================================================
	// Checks
	logic [5:0] strobe_run;
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			strobe_run <= 6'h00;
		else if (ce)
			strobe_run <= (!read_strobe_n || !write_strobe_n) ? strobe_run + 6'h01 : 6'h00;
	end

	a_strobe_single: assert property (@(posedge clk) disable iff (!reset_n)
		!(!read_strobe_n && !write_strobe_n)) else $error("read and write strobes both low");
	a_strobe_width: assert property (@(posedge clk) disable iff (!reset_n)
		(ce && strobe_run != 6'h00 && read_strobe_n && write_strobe_n)
		|-> (strobe_run == {1'b0, sed_strobe_width(move_stretch)}))
		else $error("strobe width wrong for stretch");
	a_move_cycles: assert property (@(posedge clk) disable iff (!reset_n)
		(state == SED_MOVE && at_end) |-> (cnt + 6'h01 == sed_move_clocks(move_stretch)))
		else $error("move length wrong");
	a_fetch_cycles: assert property (@(posedge clk) disable iff (!reset_n)
		(state == SED_FETCH && at_end) |-> (cnt == FETCH_LAST)) else $error("fetch not four clocks");
	a_reset_stretch: assert property (@(posedge clk)
		!reset_n |=> (stretch == RESET_STRETCH)) else $error("stretch not one after reset");
	a_ale_address: assert property (@(posedge clk) disable iff (!reset_n)
		ale |-> (low_port_oe && low_port_out == bus_addr[7:0])) else $error("address missing at ale");
	a_address_held: assert property (@(posedge clk) disable iff (!reset_n)
		(ce && !read_strobe_n) ##1 !read_strobe_n |-> $stable(high_port_out))
		else $error("address moved under strobe");
	a_stretch_kept: assert property (@(posedge clk) disable iff (!reset_n)
		(state == SED_MOVE && !at_end) |=> $stable(move_stretch)) else $error("stretch changed in move");
	a_ale_once: assert property (@(posedge clk) disable iff (!reset_n)
		(ale && ce) |=> !ale) else $error("ale longer than one clock");
	a_pointer_pick: assert property (@(posedge clk) disable iff (!reset_n)
		(accept_move && move_use_pointer && pointer_choice[0])
		|=> (bus_addr == $past({pointer1_high, pointer1_low}))) else $error("wrong pointer used");
endmodule : sed_bus

//--- core/sed_pkg.sv
// Constants, types and timing helpers for the stretched external data bus
package sed_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_POINTER0_LOW   = 8'h82;
	localparam logic [7:0] ADDR_POINTER0_HIGH  = 8'h83;
	localparam logic [7:0] ADDR_POINTER1_LOW   = 8'h84;
	localparam logic [7:0] ADDR_POINTER1_HIGH  = 8'h85;
	localparam logic [7:0] ADDR_POINTER_CHOICE = 8'h86;
	localparam logic [7:0] ADDR_CYCLE_SPEED    = 8'h8e;
	localparam logic [7:0] ADDR_HIGH_PORT      = 8'ha0;

	// ==========================================================
	// Field layouts and reset values
	localparam int         STRETCH_LSB         = 0;
	localparam int         STRETCH_MSB         = 2;
	localparam logic [7:0] SPEED_WRITE_MASK    = 8'h3f;
	localparam logic [7:0] CHOICE_WRITE_MASK   = 8'h01;
	localparam logic [7:0] RESET_CYCLE_SPEED   = 8'h01;
	localparam logic [2:0] RESET_STRETCH       = 3'h1;
	localparam logic [7:0] RESET_POINTER       = 8'h00;
	localparam logic [7:0] RESET_CHOICE        = 8'h00;
	localparam logic [7:0] RESET_HIGH_PORT     = 8'hff;
	localparam logic [7:0] RESET_LOW_PORT      = 8'hff;
	localparam int         SCRATCH_BYTES       = 256;

	// ==========================================================
	// Timing in clocks
	localparam logic [5:0] CLOCKS_PER_CYCLE    = 6'h04;
	localparam logic [5:0] BASE_MOVE_CYCLES    = 6'h02;
	localparam logic [5:0] FETCH_LAST          = 6'h03;
	localparam logic [5:0] ALE_CLOCK           = 6'h00;
	localparam logic [5:0] ADDR_LAST           = 6'h01;
	localparam logic [5:0] FETCH_STROBE_FIRST  = 6'h01;
	localparam logic [5:0] FETCH_STROBE_LAST   = 6'h02;
	localparam logic [5:0] MOVE_STROBE_FIRST   = 6'h04;
	localparam logic [5:0] WRITE_DATA_FIRST    = 6'h02;
	localparam logic [4:0] FAST_STROBE_WIDTH   = 5'h02;
	localparam int         SAMPLE_DELAY        = 3;

	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {SED_IDLE, SED_FETCH, SED_MOVE} sed_state_t;

	// Strobe width in clocks for a stretch value
	function automatic logic [4:0] sed_strobe_width(input logic [2:0] stretch);
		sed_strobe_width = (stretch == 3'h0) ? FAST_STROBE_WIDTH : {stretch, 2'b00};
	endfunction : sed_strobe_width

	// Whole move length in clocks for a stretch value
	function automatic logic [5:0] sed_move_clocks(input logic [2:0] stretch);
		sed_move_clocks = 6'(({3'h0, stretch} + BASE_MOVE_CYCLES) * CLOCKS_PER_CYCLE);
	endfunction : sed_move_clocks

endpackage : sed_pkg

//--- core/sed_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sed_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             ce,
	// Data
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;

	// ==========================================================
	// Two stages
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			stage_one <= '0;
			sync_out  <= '0;
		end
		else if (ce)
		begin
			stage_one <= pin_in;
			sync_out  <= stage_one;
		end
	end
endmodule : sed_sync

//--- tb/sed_bus_test.sv
// Self-checking bench for the stretched external data bus
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_total++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module sed_bus_test;
	import sed_pkg::*;
	// ==========================================================
	// Signals
	logic        clk = 0, reset_n = 0, ce = 1;
	logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata, scratch_rdata, fetch_data, move_rdata;
	logic [7:0]  scratch_addr = 0, scratch_wdata = 0, move_addr_low = 0, move_wdata = 0;
	logic        sfr_write = 0, scratch_write = 0, fetch_req = 0, move_req = 0;
	logic        move_write = 0, move_use_pointer = 0, fetch_ready, fetch_done, move_ready;
	logic        move_done, low_port_oe, ale, prog_strobe_n, read_strobe_n, write_strobe_n;
	logic [15:0] fetch_addr = 0, last_addr;
	logic [7:0]  low_port_in, low_port_out, high_port_out, last_wdata;
	logic [3:0]  model_lag = 0;
	int          err_total = 0, checks = 0, cyc = 0, slo = 0, fdone = 0, mdone = 0, e;
	int          seed, i, s, lat, t0, t1, ft;
	logic [7:0]  lo, d, hp;
	int          wq[$];
	logic [7:0]  fq[$];
	logic [8:0]  mq[$];
	always #25 clk = ~clk;
	// ==========================================================
	// Design and memory model
	sed_bus sed_bus_i (.clk(clk), .reset_n(reset_n), .ce(ce), .sfr_addr(sfr_addr),
		.sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.scratch_addr(scratch_addr), .scratch_write(scratch_write),
		.scratch_wdata(scratch_wdata), .scratch_rdata(scratch_rdata), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_done(fetch_done),
		.fetch_data(fetch_data), .move_req(move_req), .move_write(move_write),
		.move_use_pointer(move_use_pointer), .move_addr_low(move_addr_low),
		.move_wdata(move_wdata), .move_ready(move_ready), .move_done(move_done),
		.move_rdata(move_rdata), .low_port_in(low_port_in), .low_port_out(low_port_out),
		.low_port_oe(low_port_oe), .high_port_out(high_port_out), .ale(ale),
		.prog_strobe_n(prog_strobe_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n));
	sed_mem_model sed_mem_model_i (.clk(clk), .low_port_out(low_port_out),
		.low_port_oe(low_port_oe), .high_port_out(high_port_out), .ale(ale),
		.prog_strobe_n(prog_strobe_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .lag(model_lag), .low_port_in(low_port_in),
		.last_addr(last_addr), .last_wdata(last_wdata));
	// ==========================================================
	// Output monitor
	always @(negedge clk)
	begin
		cyc <= cyc + 1;
		if (fetch_done === 1'b1)
		begin
			d = fq.pop_front();
			fdone = cyc;
			`CHK("fetch_data", d, fetch_data)
		end
		if (move_done === 1'b1)
		begin
			mdone = cyc;
			e = mq.pop_front();
			if (e[8])
				`CHK("write_data", e[7:0], last_wdata)
			else
				`CHK("read_data", e[7:0], move_rdata)
		end
		`CHK("one_strobe", 1'b1, read_strobe_n | write_strobe_n)
		if (read_strobe_n === 1'b0 || write_strobe_n === 1'b0)
			slo = slo + 1;
		else if (slo != 0)
		begin
			e = wq.pop_front();
			`CHK("strobe_width", e, slo)
			slo = 0;
		end
	end
	// ==========================================================
	// Tasks
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_write = 1;
		@(negedge clk);
		sfr_write = 0;
	endtask : sfr_wr
	task automatic sfr_chk(input logic [7:0] a, input logic [7:0] ex);
		@(negedge clk);
		sfr_addr = a;
		@(negedge clk);
		`CHK("sfr_rdata", ex, sfr_rdata)
	endtask : sfr_chk
	task automatic move(input logic wr, input logic ptr, input logic [7:0] a,
		input logic [7:0] v, input int st, output int lt);
		int n;
		@(negedge clk);
		move_req = 1;
		move_write = wr;
		move_use_pointer = ptr;
		move_addr_low = a;
		move_wdata = v;
		model_lag = (st > 1) ? 4'(st) : 4'h0;
		n = 0;
		while (move_ready !== 1'b1 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		t0 = cyc;
		wq.push_back((st == 0) ? 2 : 4 * st);
		mq.push_back({wr, v});
		@(negedge clk);
		move_req = 0;
		n = 0;
		while (fetch_ready !== 1'b1 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		lt = n + 1;
		n = 0;
		while (mdone <= t0 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
	endtask : move
	task automatic fetch(input logic [15:0] a, input logic keep);
		int n;
		fetch_req = 1;
		fetch_addr = a;
		n = 0;
		while (fetch_ready !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		ft = cyc;
		fq.push_back(a[7:0] ^ a[15:8] ^ 8'h5a);
		@(negedge clk);
		if (!keep)
		begin
			fetch_req = 0;
			@(negedge clk);
		end
	endtask : fetch
	task automatic test_done;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	// ==========================================================
	// Watchdog
	initial
	begin
		#500000;
		err_total++;
		test_done;
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		seed = 2;
		repeat (20) @(posedge clk);
		@(negedge clk);
		reset_n = 1;
		sfr_chk(ADDR_CYCLE_SPEED, RESET_CYCLE_SPEED);
		sfr_chk(ADDR_HIGH_PORT, RESET_HIGH_PORT);
		move(1, 0, 8'h10, 8'ha5, 1, lat);
		move(0, 0, 8'h10, 8'ha5, 1, lat);
		sfr_wr(ADDR_CYCLE_SPEED, 8'hff);
		sfr_chk(ADDR_CYCLE_SPEED, 8'h3f);
		sfr_wr(ADDR_POINTER_CHOICE, 8'hff);
		sfr_chk(ADDR_POINTER_CHOICE, 8'h01);
		sfr_wr(8'h87, 8'h55);
		sfr_chk(8'h87, 8'h00);
		for (i = 0; i < 4; i++)
		begin
			@(negedge clk);
			scratch_addr = (i < 2) ? 8'(i) : 8'(254 + i - 2);
			scratch_wdata = 8'($random(seed));
			scratch_write = 1;
			@(negedge clk);
			scratch_write = 0;
			@(negedge clk);
			`CHK("scratch", scratch_wdata, scratch_rdata)
		end
		for (s = 0; s < 8; s++)
		begin
			hp = 8'($random(seed));
			lo = 8'($random(seed));
			d = 8'($random(seed));
			sfr_wr(ADDR_HIGH_PORT, hp);
			sfr_wr(ADDR_CYCLE_SPEED, 8'(s));
			move(1, 0, lo, d, s, lat);
			`CHK("move_addr", {hp, lo}, last_addr)
			`CHK("write_length", 4 * (s + 2), lat)
			move(0, 0, lo, d, s, lat);
			`CHK("move_length", 4 * (s + 2), lat)
		end
		sfr_wr(ADDR_CYCLE_SPEED, 8'h02);
		fork
			move(1, 0, 8'h20, 8'h3c, 2, lat);
			begin
				repeat (6) @(negedge clk);
				sfr_wr(ADDR_CYCLE_SPEED, 8'h07);
			end
		join
		`CHK("kept_length", 16, lat)
		move(0, 0, 8'h20, 8'h3c, 7, lat);
		`CHK("new_length", 36, lat)
		sfr_wr(ADDR_POINTER0_LOW, 8'h34);
		sfr_wr(ADDR_POINTER0_HIGH, 8'h12);
		sfr_wr(ADDR_POINTER1_LOW, 8'h78);
		sfr_wr(ADDR_POINTER1_HIGH, 8'h56);
		sfr_wr(ADDR_POINTER_CHOICE, 8'h01);
		move(1, 1, 8'h00, 8'h9e, 7, lat);
		`CHK("pointer1", 16'h5678, last_addr)
		sfr_wr(ADDR_POINTER_CHOICE, 8'h00);
		move(1, 1, 8'h00, 8'h61, 7, lat);
		`CHK("pointer0", 16'h1234, last_addr)
		sfr_wr(ADDR_POINTER_CHOICE, 8'h01);
		move(0, 1, 8'h00, 8'h9e, 7, lat);
		@(negedge clk);
		fetch(16'h4321, 0);
		repeat (12) @(negedge clk);
		lat = fdone - ft;
		sfr_wr(ADDR_CYCLE_SPEED, 8'h00);
		@(negedge clk);
		fetch(16'hbeef, 0);
		repeat (12) @(negedge clk);
		`CHK("fetch_latency", lat, fdone - ft)
		@(negedge clk);
		fetch(16'h0100, 1);
		t1 = ft;
		for (i = 1; i < 4; i++)
		begin
			fetch(16'(16'h0100 + i), (i < 3));
			`CHK("fetch_spacing", 4, ft - t1)
			t1 = ft;
		end
		repeat (20) @(negedge clk);
		`CHK("pending", 0, fq.size() + mq.size() + wq.size())
		test_done;
	end
endmodule : sed_bus_test

//--- tb/sed_mem_model.sv
// External memory model that answers on the multiplexed bus
`timescale 1ns/1ps
module sed_mem_model (
	// Clock
	input  wire logic        clk,
	// Bus pins seen from the memory side
	input  wire logic [7:0]  low_port_out,
	input  wire logic        low_port_oe,
	input  wire logic [7:0]  high_port_out,
	input  wire logic        ale,
	input  wire logic        prog_strobe_n,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	// Answer delay in clocks into the strobe
	input  wire logic [3:0]  lag,
	// Pin level and observations
	output logic      [7:0]  low_port_in,
	output logic      [15:0] last_addr,
	output logic      [7:0]  last_wdata
);
	logic [7:0] ram [0:255];
	logic [7:0] held = 8'h00;
	logic [3:0] cnt  = 4'h0;
	logic       drive;
	logic [7:0] rdat;
	always_comb rdat = !prog_strobe_n ? (last_addr[7:0] ^ last_addr[15:8] ^ 8'h5a)
		: ram[last_addr[7:0]];
	always_comb drive = !prog_strobe_n || (!read_strobe_n && cnt >= lag);
	// Released line shows the inverse of the last level
	always_comb low_port_in = low_port_oe ? low_port_out : (drive ? rdat : ~held);
	always @(posedge clk)
	begin
		held <= low_port_in;
		cnt  <= (!read_strobe_n && cnt != 4'hf) ? cnt + 4'h1 : (read_strobe_n ? 4'h0 : cnt);
		if (ale)
			last_addr <= {high_port_out, low_port_out};
		if (!write_strobe_n)
		begin
			last_wdata               <= low_port_out;
			ram[last_addr[7:0]] <= low_port_out;
		end
	end
endmodule : sed_mem_model
